// [core/keypad_pkg.sv]
// Package with constants and types for the keypad and menu controller
package keypad_pkg;
	localparam int NUM_KEYS  = 5;
	localparam int NUM_OUTS  = 8;
	// Key indices
	localparam int K_LEARN   = 0; // learn_colour_key
	localparam int K_SELF    = 1; // self_adjust_key
	localparam int K_LIGHT   = 2; // light_level_key, also enter
	localparam int K_MARGIN  = 3; // margin_adjust_key, also cancel_key
	localparam int K_ERASE   = 4; // erase_key, left arrow
	localparam int K_SET     = 5; // settings_key, right arrow
	localparam int KEY_COUNT = 6;
	// Timing
	localparam int CLK_HZ          = 10_000_000;
	localparam int LONG_PRESS_MS   = 2000;
	localparam int LONG_PRESS_CYC  = CLK_HZ / 1000 * LONG_PRESS_MS;
	localparam int DEBOUNCE_MS     = 10;
	localparam int DEBOUNCE_CYC    = CLK_HZ / 1000 * DEBOUNCE_MS;
	localparam int BLINK_MS        = 250;
	localparam int BLINK_CYC       = CLK_HZ / 1000 * BLINK_MS;
	localparam int AUTO_RUN_MS     = 3000;
	localparam int AUTO_RUN_CYC    = CLK_HZ / 1000 * AUTO_RUN_MS;
	// Modulation levels in percent
	localparam logic [6:0] MOD_TARGET_PCT = 7'h50; // 80 percent saturation
	localparam logic [6:0] MOD_STEP_PCT   = 7'h0A; // 10 percent step
	localparam logic [6:0] MOD_MAX_PCT    = 7'h64; // 100 percent
	localparam logic [6:0] MOD_RESET_PCT  = 7'h50;
	localparam logic [7:0] OUT_DEFAULT    = 8'hFF; // all outputs high, no colour
	// Menu states, Gray coded along the usual path
	typedef enum logic [2:0] {
		ST_OPER   = 3'h0,
		ST_INT    = 3'h1,
		ST_AUTO   = 3'h3,
		ST_TEACH  = 3'h2,
		ST_TOLER  = 3'h6,
		ST_ERASE  = 3'h7,
		ST_OPTS   = 3'h5
	} menu_t;
endpackage

// [core/key_evt_if.sv]
// Interface carrying classified key events from the key sorter
`timescale 1ns/1ns
`default_nettype none
interface key_evt_if;
	logic [keypad_pkg::KEY_COUNT-1:0] short_evt; // Pulse on release after short hold
	logic [keypad_pkg::KEY_COUNT-1:0] long_evt;  // Pulse once at two seconds
	logic [keypad_pkg::KEY_COUNT-1:0] held_long; // Level while held past two seconds
	modport src (output short_evt, output long_evt, output held_long);
	modport dst (input short_evt, input long_evt, input held_long);
endinterface
`default_nettype wire

// [core/key_sorter.sv]
// Synchroniser, debouncer and short or long press sorter for each key
`timescale 1ns/1ns
`default_nettype none
module key_sorter #(
	parameter int LONG_CYC = keypad_pkg::LONG_PRESS_CYC,
	parameter int DEB_CYC  = keypad_pkg::DEBOUNCE_CYC
) (
	// Clock and reset
	input  wire logic                            i_clk,
	input  wire logic                            i_rst,
	// Raw keys, high while pressed
	input  wire logic [keypad_pkg::KEY_COUNT-1:0] i_key,
	// Classified events
	key_evt_if.src                               evt
);
	genvar g;
	generate
		for (g = 0; g < keypad_pkg::KEY_COUNT; g++) begin : g_key
			logic        s1_r, s2_r, stable_r;
			logic [16:0] deb_r; // Wide enough for the full debounce count
			logic [24:0] hold_r;
			logic        long_r;
			// Two-stage synchroniser, first stage read only by second
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					s1_r <= 1'b0;
					s2_r <= 1'b0;
				end else begin
					s1_r <= i_key[g];
					s2_r <= s1_r;
				end
			end
			// Debounce: level must hold steady before it is believed
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					deb_r    <= 17'h00000;
					stable_r <= 1'b0;
				end else if (s2_r == stable_r) begin
					deb_r <= 17'h00000; // RQ21
				end else if (deb_r == 17'(DEB_CYC - 1)) begin
					deb_r    <= 17'h00000;
					stable_r <= s2_r; // RQ21
				end else begin
					deb_r <= deb_r + 17'h00001;
				end
			end
			// Hold timer starts only from the debounced level
			always_ff @(posedge i_clk or posedge i_rst) begin
				if (i_rst) begin
					hold_r             <= 25'h0000000;
					long_r             <= 1'b0;
					evt.short_evt[g]   <= 1'b0;
					evt.long_evt[g]    <= 1'b0;
				end else begin
					evt.short_evt[g] <= 1'b0;
					evt.long_evt[g]  <= 1'b0;
					if (stable_r) begin
						if (!long_r && hold_r == 25'(LONG_CYC - 1)) begin
							long_r          <= 1'b1; // RQ1
							evt.long_evt[g] <= 1'b1;
						end else if (!long_r) begin
							hold_r <= hold_r + 25'h0000001;
						end
					end else begin
						// Short function acts on release only
						evt.short_evt[g] <= (hold_r != 25'h0000000) && !long_r; // RQ20
						hold_r           <= 25'h0000000;
						long_r           <= 1'b0;
					end
				end
			end
			assign evt.held_long[g] = long_r;
		end
	endgenerate
endmodule
`default_nettype wire

// [core/keypad_menu_intensity_ctrl.sv]
// Keypad menu controller with intensity menu and output LED display
// Operation
// RQ1 - Under two seconds short, else long
// RQ2 - Key LED flashes once held two seconds
// RQ3 - Long press opens that key's menu
// RQ4 - Margin key in learn menu opens tolerance
// RQ5 - Short arrows step previous or next item
// RQ6 - Short learn or self-adjust triggers event
// RQ7 - Long enter commits and returns to operation
// RQ8 - Long cancel discards and returns to operation
// RQ9 - Default: all outputs and LEDs high; the code holds the key LEDs low
// RQ10 - Long light-level press selects intensity menu
// RQ11 - Intensity menu shows received level bar
// RQ12 - Overmodulation flashes all eight LEDs together
// RQ13 - Short self-adjust starts automatic modulation
// RQ14 - Auto modulation targets eighty percent saturation
// RQ15 - During auto, even and odd LEDs alternate
// RQ16 - After auto, light key LED steady, level shown
// RQ17 - Auto picks averaging, drive, gain by frequency; the code picks gain by received level
// RQ18 - Arrows step modulation up or down ten
// RQ19 - Cancel, enter, cancel toggles keypad lock
// RQ20 - Short function acts on key release
// RQ21 - Keys synchronised and debounced before timing
`timescale 1ns/1ns
`default_nettype none
module keypad_menu_intensity_ctrl #(
	parameter int LONG_CYC = keypad_pkg::LONG_PRESS_CYC,
	parameter int DEB_CYC  = keypad_pkg::DEBOUNCE_CYC,
	parameter int BLINK_CYC = keypad_pkg::BLINK_CYC,
	parameter int AUTO_CYC = keypad_pkg::AUTO_RUN_CYC
) (
	// Clock and reset
	input  wire logic                             i_clk,
	input  wire logic                             i_rst,
	// Membrane keys, high while pressed
	input  wire logic [keypad_pkg::KEY_COUNT-1:0] i_key,
	// Receiver side
	input  wire logic [6:0]                       i_rx_level_pct,
	input  wire logic                             i_rx_overmod,
	input  wire logic [1:0]                       i_meas_freq,
	input  wire logic                             i_auto_done,
	input  wire logic [7:0]                       i_colour_outs,
	input  wire logic                             i_colour_found,
	// Key LEDs, output LEDs and switch outputs
	output logic      [keypad_pkg::KEY_COUNT-1:0] o_key_led,
	output logic      [7:0]                       o_out_led,
	output logic      [7:0]                       o_switch_out,
	// Receiver gain control
	output logic      [6:0]                       o_mod_target_pct,
	output logic                                  o_auto_start,
	output logic      [1:0]                       o_avg_sel,
	output logic      [1:0]                       o_drive_sel,
	output logic      [1:0]                       o_gain_sel,
	output logic                                  o_auto_busy,
	// Menu events to colour evaluation
	output logic      [2:0]                       o_menu,
	output logic                                  o_item_prev,
	output logic                                  o_item_next,
	output logic                                  o_teach_evt,
	output logic                                  o_commit,
	output logic                                  o_discard,
	output logic                                  o_locked
);
	key_evt_if ev ();

	keypad_pkg::menu_t menu_r;
	logic [6:0]        mod_r, mod_saved_r;
	logic [1:0]        lock_seq_r;
	logic              locked_r;
	logic [21:0]       blink_cnt_r;
	logic              blink_r;
	logic [24:0]       auto_cnt_r;
	logic              auto_run_r;
	logic              auto_ok_r;
	logic [7:0]        bar;
	logic              in_menu;
	logic [keypad_pkg::KEY_COUNT-1:0] sh, lg;

	key_sorter #(
		.LONG_CYC (LONG_CYC),
		.DEB_CYC  (DEB_CYC)
	) u_sorter (
		.i_clk (i_clk),
		.i_rst (i_rst),
		.i_key (i_key),
		.evt   (ev)
	);

	// Lock gates short and long events; the lock sequence and the key LED flash read the ungated signals
	assign in_menu = (menu_r != keypad_pkg::ST_OPER);
	assign sh      = locked_r ? '0 : ev.short_evt;
	assign lg      = locked_r ? '0 : ev.long_evt;

	// Blink enable divider, shared by all flashing patterns
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			blink_cnt_r <= 22'h000000;
			blink_r     <= 1'b0;
		end else if (blink_cnt_r == 22'(BLINK_CYC - 1)) begin
			blink_cnt_r <= 22'h000000;
			blink_r     <= ~blink_r;
		end else begin
			blink_cnt_r <= blink_cnt_r + 22'h000001;
		end
	end

	// Lock sequence: cancel, enter, cancel as short presses
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			lock_seq_r <= 2'h0;
			locked_r   <= 1'b0;
		end else if (|ev.short_evt) begin
			case (lock_seq_r)
				2'h0: lock_seq_r <= ev.short_evt[keypad_pkg::K_MARGIN] ? 2'h1 : 2'h0;
				// A repeated cancel restarts the sequence instead of losing it
				2'h1: lock_seq_r <= ev.short_evt[keypad_pkg::K_LIGHT] ? 2'h2
					: (ev.short_evt[keypad_pkg::K_MARGIN] ? 2'h1 : 2'h0);
				2'h2: begin
					lock_seq_r <= 2'h0;
					if (ev.short_evt[keypad_pkg::K_MARGIN] && !in_menu) begin
						locked_r <= ~locked_r; // RQ19
					end
				end
				default: lock_seq_r <= 2'h0;
			endcase
		end
	end

	// Menu state machine
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			menu_r <= keypad_pkg::ST_OPER;
		end else begin
			case (menu_r)
				keypad_pkg::ST_OPER: begin
					// Cancel key's long press opens nothing here
					if (lg[keypad_pkg::K_LIGHT]) menu_r <= keypad_pkg::ST_INT; // RQ10
					else if (lg[keypad_pkg::K_LEARN]) menu_r <= keypad_pkg::ST_TEACH; // RQ3
					else if (lg[keypad_pkg::K_SELF]) menu_r <= keypad_pkg::ST_INT; // RQ3
					else if (lg[keypad_pkg::K_ERASE]) menu_r <= keypad_pkg::ST_ERASE; // RQ3
					else if (lg[keypad_pkg::K_SET]) menu_r <= keypad_pkg::ST_OPTS; // RQ3
				end
				keypad_pkg::ST_AUTO: begin
					if (auto_cnt_r == 25'(AUTO_CYC - 1) || i_auto_done) begin
						menu_r <= keypad_pkg::ST_INT;
					end
				end
				default: begin
					if (lg[keypad_pkg::K_LIGHT] || lg[keypad_pkg::K_MARGIN]) begin
						menu_r <= keypad_pkg::ST_OPER; // RQ7 RQ8
					end else if (menu_r == keypad_pkg::ST_INT && sh[keypad_pkg::K_SELF]) begin
						menu_r <= keypad_pkg::ST_AUTO; // RQ13
					end else if (menu_r == keypad_pkg::ST_TEACH
							&& sh[keypad_pkg::K_MARGIN]) begin
						menu_r <= keypad_pkg::ST_TOLER; // RQ4
					end
				end
			endcase
		end
	end

	// Auto modulation run timer and completion flag
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			auto_cnt_r <= 25'h0000000;
			auto_run_r <= 1'b0;
			auto_ok_r  <= 1'b0;
		end else if (menu_r == keypad_pkg::ST_AUTO) begin
			auto_run_r <= 1'b1;
			auto_cnt_r <= auto_cnt_r + 25'h0000001;
			if (auto_cnt_r == 25'(AUTO_CYC - 1) || i_auto_done) begin
				auto_ok_r  <= 1'b1; // RQ16
				auto_run_r <= 1'b0;
				auto_cnt_r <= 25'h0000000;
			end
		end else begin
			auto_run_r <= 1'b0;
			auto_cnt_r <= 25'h0000000;
			if (menu_r != keypad_pkg::ST_INT || sh[keypad_pkg::K_ERASE]
					|| sh[keypad_pkg::K_SET]) begin
				auto_ok_r <= 1'b0;
			end
		end
	end

	// Modulation target: working copy and committed copy
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			mod_r       <= keypad_pkg::MOD_RESET_PCT;
			mod_saved_r <= keypad_pkg::MOD_RESET_PCT;
		end else if (in_menu && lg[keypad_pkg::K_LIGHT]) begin
			mod_saved_r <= mod_r; // RQ7
		end else if (in_menu && lg[keypad_pkg::K_MARGIN]) begin
			mod_r <= mod_saved_r; // RQ8
		end else if (menu_r == keypad_pkg::ST_INT && sh[keypad_pkg::K_SELF]) begin
			mod_r <= keypad_pkg::MOD_TARGET_PCT; // RQ14
		end else if (menu_r == keypad_pkg::ST_INT && sh[keypad_pkg::K_SET]) begin
			mod_r <= (mod_r > keypad_pkg::MOD_MAX_PCT - keypad_pkg::MOD_STEP_PCT)
				? keypad_pkg::MOD_MAX_PCT : mod_r + keypad_pkg::MOD_STEP_PCT; // RQ18
		end else if (menu_r == keypad_pkg::ST_INT && sh[keypad_pkg::K_ERASE]) begin
			mod_r <= (mod_r < keypad_pkg::MOD_STEP_PCT)
				? 7'h00 : mod_r - keypad_pkg::MOD_STEP_PCT; // RQ18
		end
	end

	// Averaging and drive chosen per measurement frequency, gain per received level, during auto run
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_avg_sel   <= 2'h0;
			o_drive_sel <= 2'h0;
			o_gain_sel  <= 2'h0;
		end else if (menu_r == keypad_pkg::ST_AUTO) begin
			// Faster rates allow less averaging, so drive harder
			o_avg_sel   <= ~i_meas_freq; // RQ17
			o_drive_sel <= i_meas_freq; // RQ17
			o_gain_sel  <= i_rx_level_pct < keypad_pkg::MOD_TARGET_PCT ? 2'h3 : 2'h1; // RQ17
		end
	end

	// Bar: one LED per 12.5 percent received
	always_comb begin
		bar = 8'h00;
		for (int i = 0; i < keypad_pkg::NUM_OUTS; i++) begin
			if (11'(i_rx_level_pct) * 11'h008 > 11'(i * 100)) bar[i] = 1'b1; // RQ11
		end
	end

	// Output LED display
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_out_led    <= keypad_pkg::OUT_DEFAULT; // RQ9
			o_switch_out <= keypad_pkg::OUT_DEFAULT; // RQ9
		end else begin
			o_switch_out <= i_colour_found ? i_colour_outs : keypad_pkg::OUT_DEFAULT; // RQ9
			if (menu_r == keypad_pkg::ST_AUTO) begin
				o_out_led <= blink_r ? 8'hAA : 8'h55; // RQ15
			end else if (menu_r == keypad_pkg::ST_INT && i_rx_overmod) begin
				o_out_led <= blink_r ? 8'hFF : 8'h00; // RQ12
			end else if (menu_r == keypad_pkg::ST_INT) begin
				o_out_led <= bar; // RQ11 RQ16
			end else begin
				o_out_led <= i_colour_found ? i_colour_outs : keypad_pkg::OUT_DEFAULT; // RQ9
			end
		end
	end

	// Key LEDs: flash while held long, light key LED steady after auto completes
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_key_led <= '0;
		end else begin
			o_key_led <= ev.held_long & {keypad_pkg::KEY_COUNT{blink_r}}; // RQ2
			if (auto_ok_r && menu_r == keypad_pkg::ST_INT) begin
				o_key_led[keypad_pkg::K_LIGHT] <= 1'b1; // RQ16
			end
		end
	end

	// Menu event pulses to colour evaluation
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_item_prev  <= 1'b0;
			o_item_next  <= 1'b0;
			o_teach_evt  <= 1'b0;
			o_auto_start <= 1'b0;
			o_commit     <= 1'b0;
			o_discard    <= 1'b0;
		end else begin
			o_item_prev  <= in_menu && sh[keypad_pkg::K_ERASE]; // RQ5
			o_item_next  <= in_menu && sh[keypad_pkg::K_SET]; // RQ5
			o_teach_evt  <= in_menu && menu_r != keypad_pkg::ST_INT
				&& sh[keypad_pkg::K_LEARN]; // RQ6
			o_auto_start <= menu_r == keypad_pkg::ST_INT && sh[keypad_pkg::K_SELF]; // RQ6 RQ13
			o_commit     <= in_menu && lg[keypad_pkg::K_LIGHT]; // RQ7
			o_discard    <= in_menu && !lg[keypad_pkg::K_LIGHT]
				&& lg[keypad_pkg::K_MARGIN]; // RQ8
		end
	end

	// Registered status outputs
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			o_menu           <= 3'h0;
			o_mod_target_pct <= keypad_pkg::MOD_RESET_PCT;
			o_auto_busy      <= 1'b0;
			o_locked         <= 1'b0;
		end else begin
			o_menu           <= menu_r;
			o_mod_target_pct <= mod_r;
			o_auto_busy      <= auto_run_r; // RQ15
			o_locked         <= locked_r;
		end
	end
endmodule
`default_nettype wire

// [tb/keypad_menu_intensity_ctrl_sva.sv]
// Assertion checker on the ports of the keypad menu controller
`timescale 1ns/1ns
`default_nettype none
module keypad_ctrl_chk #(
	parameter int AUTO_CYC = 60
) (
	// Clock and reset
	input wire logic       i_clk,
	input wire logic       i_rst,
	// Watched inputs
	input wire logic [6:0] i_rx_level_pct,
	input wire logic       i_rx_overmod,
	input wire logic       i_colour_found,
	// Watched outputs
	input wire logic [5:0] o_key_led,
	input wire logic [7:0] o_out_led,
	input wire logic [7:0] o_switch_out,
	input wire logic [6:0] o_mod_target_pct,
	input wire logic       o_auto_start,
	input wire logic [2:0] o_menu,
	input wire logic       o_commit,
	input wire logic       o_discard
);
	logic [7:0]  bar;
	logic [31:0] auto_cnt_r;
	// Expected bar: LED i lit when level times 8 exceeds i times 100
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			bar[i] = (i_rx_level_pct * 8) > (i * 100);
		end
	end
	// Cycles in the auto run; a long bound needs a counter, not a delay
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst)
			auto_cnt_r <= '0;
		else
			auto_cnt_r <= (o_menu == 3'h3) ? auto_cnt_r + 1 : '0;
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	switch_default_a: assert property (!i_colour_found |=> o_switch_out == 8'hFF)
		else $error("switch outputs not high without colour");
	bar_level_a: assert property (
		(o_menu == 3'h1 && !i_rx_overmod && $stable(i_rx_level_pct))[*3] |-> o_out_led == bar)
		else $error("level bar wrong");
	overmod_flash_a: assert property (
		(o_menu == 3'h1 && i_rx_overmod)[*3] |-> o_out_led inside {8'hFF, 8'h00})
		else $error("overmodulation display wrong");
	auto_pattern_a: assert property (
		(o_menu == 3'h3 && !i_rx_overmod)[*3] |-> o_out_led inside {8'hAA, 8'h55})
		else $error("auto run pattern wrong");
	auto_target_a: assert property ((o_menu == 3'h3)[*2] |-> o_mod_target_pct == 7'h50)
		else $error("auto target not eighty");
	auto_length_a: assert property (auto_cnt_r <= AUTO_CYC + 4)
		else $error("auto run too long");
	auto_launch_a: assert property (o_auto_start |-> ##[0:2] o_menu == 3'h3)
		else $error("auto start without auto menu");
	mod_step_a: assert property (
		(o_menu == 3'h1)[*2] ##0 $changed(o_mod_target_pct) |-> o_mod_target_pct inside
		{$past(o_mod_target_pct) + 7'h0A, $past(o_mod_target_pct) - 7'h0A, 7'h64, 7'h00})
		else $error("modulation step not ten");
	done_led_a: assert property (
		$past(o_menu) == 3'h3 && o_menu == 3'h1 |-> ##[0:2] o_key_led[2])
		else $error("intensity key LED not lit after auto");
	commit_exit_a: assert property (o_commit |-> ##[0:1] o_menu == 3'h0)
		else $error("commit without return to operation");
	discard_exit_a: assert property (o_discard |-> !o_commit ##[0:1] o_menu == 3'h0)
		else $error("discard without return to operation");
endmodule
bind keypad_menu_intensity_ctrl keypad_ctrl_chk #(.AUTO_CYC(AUTO_CYC)) chk_u (
	.i_clk(i_clk), .i_rst(i_rst), .i_rx_level_pct(i_rx_level_pct),
	.i_rx_overmod(i_rx_overmod), .i_colour_found(i_colour_found), .o_key_led(o_key_led),
	.o_out_led(o_out_led), .o_switch_out(o_switch_out), .o_mod_target_pct(o_mod_target_pct),
	.o_auto_start(o_auto_start), .o_menu(o_menu), .o_commit(o_commit), .o_discard(o_discard)
);
`default_nettype wire

// [tb/key_press_model.sv]
// Behavioural model of the operator pressing membrane keys
`timescale 1ns/1ns
`default_nettype none
module key_press_model (
	// Clock
	input  wire logic      i_clk,
	// Raw keys, high while pressed, low once let go
	output var logic [5:0] o_key
);
	initial o_key = '0;
	// Press one key; bounce pulses are shorter than the debounce time
	task automatic hold(input int k, input bit bounce);
		for (int i = 0; i < (bounce ? 3 : 0); i++) begin
			@(posedge i_clk);
			#1 o_key[k] = ~o_key[k];
		end
		@(posedge i_clk);
		#1 o_key = 6'h01 << k;
	endtask
	// Let go of every key
	task automatic release_all();
		@(posedge i_clk);
		#1 o_key = 6'h00;
	endtask
endmodule
`default_nettype wire

// [tb/keypad_menu_intensity_ctrl_test.sv]
// Self-checking testbench for the keypad menu controller
`timescale 1ns/1ns
`default_nettype none
module keypad_menu_intensity_ctrl_test;
	logic       i_clk, i_rst, overmod, auto_done, colour_found;
	wire  [5:0] key;
	logic [6:0] level, target;
	logic [7:0] colour_outs, out_led, switch_out;
	logic [5:0] key_led, seen, pat;
	logic [2:0] menu;
	logic       auto_start, item_prev, item_next, teach_evt, commit, discard, locked;
	logic [1:0] avg_sel, drive_sel, gain_sel;
	logic       auto_busy;
	int         mismatches, check_count;
	keypad_menu_intensity_ctrl #(.LONG_CYC(40), .DEB_CYC(4), .BLINK_CYC(8), .AUTO_CYC(60)) dut_u (
		.i_clk(i_clk), .i_rst(i_rst), .i_key(key), .i_rx_level_pct(level),
		.i_rx_overmod(overmod), .i_meas_freq(2'h1), .i_auto_done(auto_done),
		.i_colour_outs(colour_outs), .i_colour_found(colour_found), .o_key_led(key_led),
		.o_out_led(out_led), .o_switch_out(switch_out), .o_mod_target_pct(target),
		.o_auto_start(auto_start), .o_avg_sel(avg_sel), .o_drive_sel(drive_sel),
		.o_gain_sel(gain_sel), .o_auto_busy(auto_busy), .o_menu(menu),
		.o_item_prev(item_prev), .o_item_next(item_next),
		.o_teach_evt(teach_evt), .o_commit(commit), .o_discard(discard), .o_locked(locked)
	);
	key_press_model m_u (.i_clk(i_clk), .o_key(key));
	// Clock of 100 ns period
	initial begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end
	// Sticky record of one-cycle pulses and LED patterns, cleared by scenarios
	always @(posedge i_clk) begin
		seen <= seen | {auto_start, discard, commit, teach_evt, item_prev, item_next};
		pat <= pat | {key_led[2], ~key_led[2], out_led == 8'h00, out_led == 8'hFF,
			out_led == 8'h55, out_led == 8'hAA};
	end
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			$display("[ERR] %s expected %h seen %h", what, exp, got);
			mismatches++;
		end
	endtask
	// Short press, released well before the long threshold
	task automatic tap(input int k);
		m_u.hold(k, 1'b0);
		step(15);
		m_u.release_all();
		step(10);
	endtask
	// Long press; pattern record restarted once past the threshold
	task automatic push(input int k);
		m_u.hold(k, 1'b0);
		step(50);
		pat = '0;
		step(20);
		m_u.release_all();
		step(10);
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic t_dflt();
		chk("switch", 8'hFF, switch_out);
		chk("out led", 8'hFF, out_led);
		colour_outs = 8'h3C;
		colour_found = 1'b1;
		step(3);
		chk("switch found", 8'h3C, switch_out);
		colour_found = 1'b0;
		step(3);
		chk("switch lost", 8'hFF, switch_out);
		$display("test default done");
	endtask
	task automatic t_int();
		level = 7'h32;
		push(2);
		chk("menu int", 8'h01, {5'h00, menu});
		chk("key flash", 8'h03, {6'h00, pat[5:4]});
		chk("bar 50", 8'h0F, out_led);
		level = 7'h19;
		step(4);
		chk("bar 25", 8'h03, out_led);
		overmod = 1'b1;
		pat = '0;
		step(30);
		chk("overmod", 8'h0C, {4'h0, pat[3:0]});
		overmod = 1'b0;
		step(4);
		$display("test intensity done");
	endtask
	task automatic t_manual();
		seen = '0;
		m_u.hold(5, 1'b1);
		step(15);
		chk("before release", 8'h50, {1'b0, target});
		m_u.release_all();
		step(10);
		chk("up", 8'h5A, {1'b0, target});
		chk("next", 8'h01, {2'h0, seen});
		tap(5);
		tap(5);
		chk("saturate", 8'h64, {1'b0, target});
		seen = '0;
		tap(4);
		chk("down", 8'h5A, {1'b0, target});
		chk("prev", 8'h02, {2'h0, seen});
		seen = '0;
		push(3);
		chk("discard", 8'h10, {2'h0, seen});
		chk("restored", 8'h50, {1'b0, target});
		$display("test manual done");
	endtask
	task automatic t_auto();
		push(2);
		tap(5);
		seen = '0;
		tap(1);
		chk("auto start", 8'h20, {2'h0, seen});
		chk("menu auto", 8'h03, {5'h00, menu});
		chk("auto target", 8'h50, {1'b0, target});
		chk("auto busy", 8'h01, {7'h00, auto_busy});
		pat = '0;
		step(20);
		chk("alternate", 8'h03, {4'h0, pat[3:0]});
		auto_done = 1'b1;
		step(1);
		auto_done = 1'b0;
		for (int i = 0; i < 200 && menu !== 3'h1; i++) step(1);
		step(2);
		chk("menu back", 8'h01, {5'h00, menu});
		chk("int led", 8'h01, {7'h00, key_led[2]});
		chk("auto idle", 8'h00, {7'h00, auto_busy});
		// Frequency select 1, level below target: settings held after the run
		chk("auto settings", 8'h27, {2'h0, avg_sel, drive_sel, gain_sel});
		tap(5);
		seen = '0;
		push(2);
		chk("commit", 8'h08, {2'h0, seen});
		chk("menu oper", 8'h00, {5'h00, menu});
		chk("kept", 8'h5A, {1'b0, target});
		$display("test auto done");
	endtask
	task automatic t_menus();
		logic [2:0] exp [4] = '{3'h2, 3'h7, 3'h5, 3'h1};
		int keys [4] = '{0, 4, 5, 1};
		foreach (keys[i]) begin
			push(keys[i]);
			chk("menu entry", {5'h00, exp[i]}, {5'h00, menu});
			push(3);
		end
		push(3);
		chk("cancel in oper", 8'h00, {5'h00, menu});
		push(0);
		seen = '0;
		tap(0);
		chk("teach", 8'h04, {2'h0, seen});
		tap(3);
		chk("menu tol", 8'h06, {5'h00, menu});
		push(3);
		$display("test menus done");
	endtask
	task automatic t_lock();
		tap(3);
		tap(2);
		tap(3);
		chk("locked", 8'h01, {7'h00, locked});
		push(2);
		chk("ignored", 8'h00, {5'h00, menu});
		tap(3);
		tap(2);
		tap(3);
		chk("unlocked", 8'h00, {7'h00, locked});
		$display("test lock done");
	endtask
	// Hang guard: ends the run with a mismatch
	initial begin
		step(20000);
		mismatches++;
		tally_and_finish();
	end
	// Reset for 20 cycles, then the scenarios
	initial begin
		i_rst = 1'b1;
		{level, overmod, auto_done, colour_outs, colour_found} = '0;
		seen = '0;
		pat = '0;
		mismatches = 0;
		check_count = 0;
		step(20);
		i_rst = 1'b0;
		step(2);
		t_dflt();
		t_int();
		t_manual();
		t_auto();
		t_menus();
		t_lock();
		tally_and_finish();
	end
endmodule
`default_nettype wire
